// *** src/gain_engine_regs.sv ***
// Gain-engine register bank: profile 3, control, mode and wait time over APB
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
`include "tgc_regs.svh"
module gain_engine_regs
    import tgc_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              ext_start,
    input  wire logic [1:0]        profile_pins,
    output profile3_t              prof3,
    output gain_mode_t             gain_mode,
    output logic [1:0]             active_profile,
    output logic                   curve_slope_lsb,
    output logic [1:0]             mem_bank,
    output logic [8:0]             fixed_gain_code,
    output logic                   fixed_gain_active,
    output logic                   ramp_start
);
    localparam int NREG = 8;
    localparam logic [15:0] RST_VAL [NREG] = '{
        `RST_P3_GAIN, `RST_P3_STEP, `RST_P3_INDEX, `RST_ZERO,
        `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO
    };
    localparam logic [2:0] SLOT_GAIN    = 3'(`IDX_P3_GAIN - `IDX_BASE);
    localparam logic [2:0] SLOT_STEP    = 3'(`IDX_P3_STEP - `IDX_BASE);
    localparam logic [2:0] SLOT_INDEX   = 3'(`IDX_P3_INDEX - `IDX_BASE);
    localparam logic [2:0] SLOT_START_T = 3'(`IDX_P3_START_T - `IDX_BASE);
    localparam logic [2:0] SLOT_HOLD_T  = 3'(`IDX_P3_HOLD_T - `IDX_BASE);
    localparam logic [2:0] SLOT_CONTROL = 3'(`IDX_CONTROL - `IDX_BASE);
    localparam logic [2:0] SLOT_MODE    = 3'(`IDX_MODE - `IDX_BASE);
    localparam logic [2:0] SLOT_WAIT    = 3'(`IDX_WAIT - `IDX_BASE);

    logic [15:0]       regs [NREG];
    logic [ADDR_W-3:0] word_addr;
    logic [ADDR_W-3:0] rel_addr;
    logic              hit;
    logic [2:0]        slot;
    logic              wr_en;
    logic              rd_setup;
    logic              manual_req;
    logic [15:0]       ctl;
    logic [15:0]       mode_reg;

    if (ADDR_W < 10 || ADDR_W > 32) begin : g_chk
        $error("ADDR_W must cover the bank and stay within 32 bits");
    end

    // Printed offsets are word indices; the byte address is four times that
    assign word_addr = paddr[ADDR_W-1:2];
    assign rel_addr  = word_addr - (ADDR_W-2)'(`IDX_BASE);
    assign hit       = (paddr[1:0] == 2'h0) && (word_addr >= (ADDR_W-2)'(`IDX_BASE))
                       && (rel_addr < (ADDR_W-2)'(NREG));
    assign slot      = rel_addr[2:0];

    // Zero wait states; every access completes in its first access cycle
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !hit;
    assign wr_en    = psel && penable && pwrite && hit;
    assign rd_setup = psel && !penable && !pwrite;

    for (genvar i = 0; i < NREG; i++) begin : g_reg
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                regs[i] <= RST_VAL[i];
            end else if (wr_en && slot == 3'(i)) begin
                regs[i] <= pwdata[15:0];
            end
        end
    end

    // Read data is fetched in the setup cycle so prdata comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= hit ? {16'h0000, regs[slot]} : 32'h0000_0000;
        end
    end

    assign ctl      = regs[SLOT_CONTROL];
    assign mode_reg = regs[SLOT_MODE];

    // The start bit is stored as written, but only the write itself fires
    assign manual_req = wr_en && (slot == SLOT_CONTROL) && pwdata[`CTL_MAN_START];

    always_comb begin
        prof3.start_gain           = regs[SLOT_GAIN][15:8];
        prof3.stop_gain            = regs[SLOT_GAIN][7:0];
        prof3.rise_step            = regs[SLOT_STEP][15:8];
        prof3.prof3_fall_increment = regs[SLOT_STEP][7:0];
        prof3.start_index          = regs[SLOT_INDEX][15:8];
        prof3.stop_index           = regs[SLOT_INDEX][7:0];
        prof3.start_time           = regs[SLOT_START_T];
        prof3.hold_time            = regs[SLOT_HOLD_T];
    end

    assign curve_slope_lsb   = ctl[`CTL_SLOPE_BIT];
    assign mem_bank          = ctl[`CTL_BANK_HI:`CTL_BANK_LO];
    assign gain_mode         = gain_mode_t'(mode_reg[`MODE_SEL_HI:`MODE_SEL_LO]);
    assign fixed_gain_active = (gain_mode == MODE_FIXED);
    // Code is held at zero outside fixed mode so a stale value never leaks out
    assign fixed_gain_code   = fixed_gain_active ? ctl[`CTL_FIX_HI:0] : 9'h000;

    tgc_start_gen #(
        .WAIT_W      (16)
    ) u_start (
        .pclk        (pclk),
        .presetn     (presetn),
        .int_enable  (ctl[`CTL_INT_START]),
        .wait_time   (regs[SLOT_WAIT]),
        .manual_req  (manual_req),
        .ext_start   (ext_start),
        .start_pulse (ramp_start)
    );

    tgc_profile_sel u_prof (
        .pclk                 (pclk),
        .presetn              (presetn),
        .profile_pin_override (mode_reg[`MODE_OVR_BIT]),
        .reg_profile          (mode_reg[`MODE_PROF_HI:`MODE_PROF_LO]),
        .profile_pins         (profile_pins),
        .active_profile       (active_profile)
    );

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_gain_write : assert property (
        wr_en && slot == SLOT_GAIN |=> prof3.start_gain == $past(pwdata[15:8])
            && prof3.stop_gain == $past(pwdata[7:0]))
        else $error("profile 3 gain fields did not take the write");

    chk_step_write : assert property (
        wr_en && slot == SLOT_STEP |=> prof3.rise_step == $past(pwdata[15:8])
            && prof3.prof3_fall_increment == $past(pwdata[7:0]))
        else $error("profile 3 step fields did not take the write");

    chk_index_write : assert property (
        wr_en && slot == SLOT_INDEX |=> prof3.start_index == $past(pwdata[15:8])
            && prof3.stop_index == $past(pwdata[7:0]))
        else $error("profile 3 index fields did not take the write");

    chk_time_write : assert property (
        wr_en && (slot == SLOT_START_T || slot == SLOT_HOLD_T)
        |=> (prof3.start_time == $past(pwdata[15:0]) || $past(slot) != SLOT_START_T)
            && (prof3.hold_time == $past(pwdata[15:0]) || $past(slot) != SLOT_HOLD_T))
        else $error("profile 3 time fields did not take the write");

    chk_time_hold : assert property (
        !(wr_en && (slot == SLOT_START_T || slot == SLOT_HOLD_T))
        |=> $stable(prof3.start_time) && $stable(prof3.hold_time))
        else $error("profile 3 time changed without a write");

    chk_slope_bank : assert property (
        wr_en && slot == SLOT_CONTROL |=> curve_slope_lsb == $past(pwdata[`CTL_SLOPE_BIT])
            && mem_bank == $past(pwdata[`CTL_BANK_HI:`CTL_BANK_LO]))
        else $error("slope lsb or memory bank did not follow the control write");

    chk_ext_start : assert property (
        !ctl[`CTL_INT_START] && !manual_req |=> ramp_start == $past(ext_start))
        else $error("external start not passed through in external start mode");

    chk_ext_ignored : assert property (
        ctl[`CTL_INT_START] && ext_start && !manual_req && u_start.count != 16'h0000
        |=> !ramp_start)
        else $error("external start leaked through in periodic mode");

    chk_manual_shot : assert property (
        manual_req |=> ramp_start)
        else $error("manual start write gave no ramp start");

    chk_manual_zero : assert property (
        wr_en && slot == SLOT_CONTROL && !pwdata[`CTL_MAN_START] |-> !manual_req)
        else $error("writing zero to manual start fired a start");

    chk_fixed_gain : assert property (
        wr_en && slot == SLOT_CONTROL && gain_mode == MODE_FIXED
        |=> fixed_gain_code == $past(pwdata[`CTL_FIX_HI:0]))
        else $error("fixed gain code not applied in fixed mode");

    chk_mode_sel : assert property (
        wr_en && slot == SLOT_MODE |=> gain_mode == gain_mode_t'($past(pwdata[15:14]))
            && fixed_gain_active == ($past(pwdata[15:14]) == 2'h2))
        else $error("gain mode does not follow the mode write");

    chk_period : assert property (
        ctl[`CTL_INT_START] && regs[SLOT_WAIT] == 16'h0005 && ramp_start
        && !$past(manual_req) && !$past(wr_en) ##0 (!wr_en)[*7]
        |-> ramp_start)
        else $error("periodic start spacing wrong for wait time of five");

    chk_profile_pins : assert property (
        !mode_reg[`MODE_OVR_BIT] |=> active_profile == $past(profile_pins))
        else $error("profile pins not followed with override clear");

    chk_profile_reg : assert property (
        mode_reg[`MODE_OVR_BIT]
        |=> active_profile == $past(mode_reg[`MODE_PROF_HI:`MODE_PROF_LO]))
        else $error("register profile not used with override set");

    chk_unmapped : assert property (
        psel && penable && !hit |-> pslverr && !wr_en)
        else $error("unmapped access not flagged");

    cov_manual : cover property (manual_req ##1 ramp_start);
    cov_periodic : cover property (
        ctl[`CTL_INT_START] && ramp_start ##[1:20] ramp_start);
    cov_fixed : cover property (fixed_gain_active && fixed_gain_code != 9'h000);
    cov_override : cover property (mode_reg[`MODE_OVR_BIT] && active_profile == 2'h3);
endmodule : gain_engine_regs

// *** src/tgc_pkg.sv ***
// Types shared by the gain-engine register bank
package tgc_pkg;
    typedef enum logic [1:0] {
        MODE_EXT_NONUNI = 2'h0,
        MODE_RAMP       = 2'h1,
        MODE_FIXED      = 2'h2,
        MODE_INT_NONUNI = 2'h3
    } gain_mode_t;

    typedef struct packed {
        logic [7:0]  start_gain;
        logic [7:0]  stop_gain;
        logic [7:0]  rise_step;
        logic [7:0]  prof3_fall_increment;
        logic [7:0]  start_index;
        logic [7:0]  stop_index;
        logic [15:0] start_time;
        logic [15:0] hold_time;
    } profile3_t;
endpackage : tgc_pkg

// *** src/tgc_profile_sel.sv ***
// Active gain profile selection from pins or register field
`timescale 1ns/1ns
module tgc_profile_sel (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       profile_pin_override,
    input  wire logic [1:0] reg_profile,
    input  wire logic [1:0] profile_pins,
    output logic [1:0]      active_profile
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_profile <= 2'h0;
        end else begin
            active_profile <= profile_pin_override ? reg_profile : profile_pins;
        end
    end
endmodule : tgc_profile_sel

// *** src/tgc_regs.svh ***
// Register map constants for the gain-profile-3 and gain-engine control bank
// Contract
// - Profile 3 start gain, bits 15:8, read/write, resets to zero.
// - Profile 3 stop gain, bits 7:0, read/write, resets to 9Fh.
// - Profile 3 rising step, bits 15:8, read/write, resets to zero.
// - Profile 3 falling step, bits 7:0, read/write, resets to FFh.
// - Profile 3 start index, bits 15:8, resets zero, internal non-uniform mode.
// - Profile 3 stop index, bits 7:0, resets 9Fh, internal non-uniform mode.
// - Profile 3 start time, 16-bit read/write, resets to zero.
// - Profile 3 hold time, 16-bit read/write, resets to zero.
// - Control bit 15 is slope factor lsb, resets to zero.
// - Control bit 14 picks external start (0) or internal periodic start (1).
// - Control bits 13:12 pick the gain memory bank, reset zero.
// - Writing 1 to control bit 10 issues one ramp start; 0 does nothing.
// - Fixed-gain mode applies control bits 8:0 as constant gain code.
// - Two-bit mode: ext non-uniform, up/down ramp, fixed, int non-uniform.
// - Wait-time register sets period between internal periodic starts.
// - Override bit 0 uses profile pins; 1 uses register profile field.
`ifndef TGC_REGS_SVH
`define TGC_REGS_SVH

`define IDX_BASE        8'hb0
`define IDX_P3_GAIN     8'hb0
`define IDX_P3_STEP     8'hb1
`define IDX_P3_INDEX    8'hb2
`define IDX_P3_START_T  8'hb3
`define IDX_P3_HOLD_T   8'hb4
`define IDX_CONTROL     8'hb5
`define IDX_MODE        8'hb6
`define IDX_WAIT        8'hb7

`define RST_P3_GAIN     16'h009f
`define RST_P3_STEP     16'h00ff
`define RST_P3_INDEX    16'h009f
`define RST_ZERO        16'h0000

`define CTL_SLOPE_BIT   15
`define CTL_INT_START   14
`define CTL_BANK_HI     13
`define CTL_BANK_LO     12
`define CTL_MAN_START   10
`define CTL_FIX_HI      8
`define MODE_SEL_HI     15
`define MODE_SEL_LO     14
`define MODE_PROF_HI    13
`define MODE_PROF_LO    12
`define MODE_OVR_BIT    11

`endif

// *** src/tgc_start_gen.sv ***
// Ramp start source: external, internal periodic or single-shot
`timescale 1ns/1ns
module tgc_start_gen #(
    parameter int WAIT_W = 16
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              int_enable,
    input  wire logic [WAIT_W-1:0] wait_time,
    input  wire logic              manual_req,
    input  wire logic              ext_start,
    output logic                   start_pulse
);
    logic [WAIT_W-1:0] count;
    logic              tick;

    if (WAIT_W < 1) begin : g_chk
        $error("WAIT_W must be at least 1");
    end

    assign tick = int_enable && (count == '0);

    // Reload while disabled so the first start comes a full period after enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (!int_enable || tick) begin
            count <= wait_time;
        end else begin
            count <= count - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_pulse <= 1'b0;
        end else begin
            start_pulse <= (int_enable ? tick : ext_start) | manual_req;
        end
    end

    chk_periodic_tick : assert property (@(posedge pclk) disable iff (!presetn)
        tick |=> start_pulse)
        else $error("periodic start missing after count expiry");
endmodule : tgc_start_gen

// *** verif/testbench.sv ***
// Self-checking bench for the gain-engine register bank
`timescale 1ns/1ns
module testbench;
    import tgc_pkg::*;
    typedef struct packed {
        logic [7:0]  idx;
        logic [15:0] rst;
        logic [15:0] wval;
    } row_t;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_start = 1'b0;
    logic [1:0]  profile_pins = 2'b00;
    profile3_t   prof3;
    gain_mode_t  gain_mode;
    logic [1:0]  active_profile;
    logic        curve_slope_lsb;
    logic [1:0]  mem_bank;
    logic [8:0]  fixed_gain_code;
    logic        fixed_gain_active;
    logic        ramp_start;
    logic [31:0] rd;
    logic        err;
    int          miscompares = 0;
    int          total_checks = 0;
    int          ramp_cnt = 0;
    int          cyc = 0;
    int          last_cyc = 0;
    int          ramp_gap = 0;
    int          c0;
    row_t        rows [6];

    gain_engine_regs #(.ADDR_W(12)) gain_engine_regs_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_start(ext_start), .profile_pins(profile_pins), .prof3(prof3),
        .gain_mode(gain_mode), .active_profile(active_profile),
        .curve_slope_lsb(curve_slope_lsb), .mem_bank(mem_bank),
        .fixed_gain_code(fixed_gain_code), .fixed_gain_active(fixed_gain_active),
        .ramp_start(ramp_start)
    );

    always #2 pclk = ~pclk;

    // Pulse counter and spacing, so start checks never hinge on one exact cycle
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (ramp_start === 1'b1) begin
            ramp_cnt <= ramp_cnt + 1;
            ramp_gap <= cyc - last_cyc;
            last_cyc <= cyc;
        end
    end

    task automatic conclude;
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    task automatic check(input string name, input logic [79:0] exp, input logic [79:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Entered just after a rising edge; leaves one idle edge so no signal is set twice at once
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [15:0] wd);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= {16'h0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            miscompares++;
            conclude();
        end
        @(posedge pclk);
    endtask : apb

    task automatic wreg(input logic [7:0] idx, input logic [15:0] wd);
        apb(1'b1, {2'b00, idx, 2'b00}, wd);
        check("write error flag", 1'b0, err);
    endtask : wreg

    task automatic rreg(input logic [7:0] idx, input logic [15:0] exp);
        apb(1'b0, {2'b00, idx, 2'b00}, 16'h0000);
        check("read error flag", 1'b0, err);
        check($sformatf("reg %h", idx), {16'h0000, exp}, rd);
    endtask : rreg

    task automatic ext_pulse;
        ext_start <= 1'b1;
        @(posedge pclk);
        ext_start <= 1'b0;
        repeat (20) @(posedge pclk);
    endtask : ext_pulse

    initial begin
        rows[0] = '{8'hb0, 16'h009f, 16'ha55a};
        rows[1] = '{8'hb1, 16'h00ff, 16'h3c7e};
        rows[2] = '{8'hb2, 16'h009f, 16'h1234};
        rows[3] = '{8'hb3, 16'h0000, 16'hfedc};
        rows[4] = '{8'hb4, 16'h0000, 16'h8001};
        rows[5] = '{8'hb5, 16'h0000, 16'hb1a5};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("prof3 reset", {16'h009f, 16'h00ff, 16'h009f, 32'h0}, prof3);
        foreach (rows[i]) begin
            rreg(rows[i].idx, rows[i].rst);
            wreg(rows[i].idx, rows[i].wval);
            rreg(rows[i].idx, rows[i].wval);
        end
        check("prof3 view", {64'ha55a_3c7e_1234_fedc, 16'h8001}, prof3);
        check("slope lsb", 1'b1, curve_slope_lsb);
        check("memory bank", 2'b11, mem_bank);
        check("no stray start", 0, ramp_cnt);
        $display("test register table done");
        for (int m = 0; m < 4; m++) begin
            wreg(8'hb6, 16'(m << 14));
            check("gain mode", m, gain_mode);
            check("fixed active", m == 2, fixed_gain_active);
            check("fixed code", (m == 2) ? 9'h1a5 : 9'h000, fixed_gain_code);
            if (m == 2) begin
                wreg(8'hb5, 16'h30c3);
                check("fixed code rewrite", 9'h0c3, fixed_gain_code);
            end
        end
        $display("test modes done");
        profile_pins <= 2'b10;
        repeat (3) @(posedge pclk);
        check("profile from pins", 2'b10, active_profile);
        wreg(8'hb6, 16'h3800);
        repeat (2) @(posedge pclk);
        check("profile from field", 2'b11, active_profile);
        wreg(8'hb6, 16'h0000);
        $display("test profile select done");
        c0 = ramp_cnt;
        wreg(8'hb5, 16'hb5a5);
        repeat (4) @(posedge pclk);
        check("manual start", c0 + 1, ramp_cnt);
        wreg(8'hb5, 16'hb5a5);
        wreg(8'hb5, 16'hb1a5);
        repeat (4) @(posedge pclk);
        check("manual rewrite and zero", c0 + 2, ramp_cnt);
        ext_pulse();
        check("external start", c0 + 3, ramp_cnt);
        wreg(8'hb7, 16'd200);
        wreg(8'hb5, 16'h4000);
        c0 = ramp_cnt;
        ext_pulse();
        check("external ignored", c0, ramp_cnt);
        wreg(8'hb5, 16'h0000);
        wreg(8'hb7, 16'd5);
        wreg(8'hb5, 16'h4000);
        repeat (40) @(posedge pclk);
        check("periodic gap", 6, ramp_gap);
        wreg(8'hb5, 16'h0000);
        $display("test ramp start done");
        apb(1'b1, 12'h2e0, 16'h1234);
        check("unmapped write error", 1'b1, err);
        apb(1'b0, 12'h2e0, 16'h0000);
        check("unmapped read error", 1'b1, err);
        check("unmapped read data", 32'h0000_0000, rd);
        apb(1'b1, 12'h2c1, 16'h0000);
        check("misaligned error", 1'b1, err);
        rreg(8'hb0, 16'ha55a);
        $display("test refusals done");
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        check("prof3 second reset", {16'h009f, 16'h00ff, 16'h009f, 32'h0}, prof3);
        presetn <= 1'b1;
        @(posedge pclk);
        rreg(8'hb5, 16'h0000);
        $display("test second reset done");
        conclude();
    end
endmodule : testbench
